// File: pfg_pkg.sv
// pfg_pkg: constants and types for the port F gpio block with change notice.
// assumes a 32-bit register port with byte offsets inside the peripheral region.
package pfg_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned PIN_W  = 16;

    // register block base offsets
    localparam logic [ADDR_W-1:0] OFS_DIRECTION = 16'h6140;
    localparam logic [ADDR_W-1:0] OFS_READBACK  = 16'h6150;
    localparam logic [ADDR_W-1:0] OFS_LATCH     = 16'h6160;
    localparam logic [ADDR_W-1:0] OFS_OPENDRAIN = 16'h6170;
    localparam logic [ADDR_W-1:0] OFS_CHANGECTL = 16'h6180;

    // alias sub-offsets, in words, inside each 16-byte group
    localparam logic [1:0] ALIAS_BASE = 2'h0;
    localparam logic [1:0] ALIAS_CLR  = 2'h1;
    localparam logic [1:0] ALIAS_SET  = 2'h2;
    localparam logic [1:0] ALIAS_INV  = 2'h3;

    // implemented-bit masks, which also give the direction reset value, then the open-drain and latch reset values
    localparam logic [PIN_W-1:0] MASK_SMALL = 16'h003b;
    localparam logic [PIN_W-1:0] MASK_LARGE = 16'h313f;
    localparam logic [PIN_W-1:0] OPENDRAIN_RST = 16'h0000;
    localparam logic [PIN_W-1:0] LATCH_RST     = 16'h0000;

    // change-notice control fields
    localparam int unsigned CTL_ENABLE_BIT = 15;
    localparam int unsigned CTL_HALT_BIT   = 13;
    localparam logic [PIN_W-1:0] CTL_MASK  = 16'ha000;
    localparam logic [PIN_W-1:0] CTL_RST   = 16'h0000;

    typedef enum logic [2:0] {
        PFG_SEL_NONE = 3'b000,
        PFG_SEL_DIR  = 3'b001,
        PFG_SEL_RB   = 3'b010,
        PFG_SEL_LAT  = 3'b011,
        PFG_SEL_ODC  = 3'b100,
        PFG_SEL_CTL  = 3'b101
    } pfg_sel_type;

    typedef struct packed {
        logic [PIN_W-1:0] out;
        logic [PIN_W-1:0] oe;
    } pfg_pad_type;
endpackage : pfg_pkg

// File: pfg_pin_sync.sv
// pfg_pin_sync: two-flop synchroniser per pin plus change detection.
// assumes pins are asynchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module pfg_pin_sync
    import pfg_pkg::*;
(
    input  wire logic             ref_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [PIN_W-1:0] pins_i,
    input  wire logic [PIN_W-1:0] mask_i,
    output logic      [PIN_W-1:0] level_o,
    output logic      [PIN_W-1:0] change_o
);
    logic [PIN_W-1:0] meta_q;
    logic [PIN_W-1:0] sync_q;
    logic [PIN_W-1:0] prev_q;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pins_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o  = sync_q & mask_i;
    assign change_o = (sync_q ^ prev_q) & mask_i;
endmodule // pfg_pin_sync
`default_nettype wire

// File: pfg_alias_upd.sv
// pfg_alias_upd: applies a plain, clear, set or invert write to a register value.
// assumes the caller supplies mask_i; unimplemented bits are cleared here.
`timescale 1ns/1ps
`default_nettype none
module pfg_alias_upd
    import pfg_pkg::*;
(
    input  wire logic [PIN_W-1:0] cur_i,
    input  wire logic [PIN_W-1:0] wdata_i,
    input  wire logic [1:0]       alias_i,
    input  wire logic [PIN_W-1:0] mask_i,
    output logic      [PIN_W-1:0] next_o
);
    always_comb begin
        case (alias_i)
            ALIAS_CLR: next_o = cur_i & ~wdata_i;
            ALIAS_SET: next_o = cur_i | wdata_i;
            ALIAS_INV: next_o = cur_i ^ wdata_i;
            default:   next_o = wdata_i;
        endcase
        next_o = next_o & mask_i;
    end
endmodule // pfg_alias_upd
`default_nettype wire

// File: pfg_port.sv
// pfg_port: port F gpio registers, pad drive and change-notice flag.
// assumes a single-cycle strobe register port; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - each register has clear, set, invert aliases at +4, +8, +C.
// - direction resets to 003B small variant, 313F large, upper half zero.
// - unimplemented bits and upper halfword read zero, ignore writes.
// - readback and latch undefined at reset (the latch resets to zero here); open-drain select resets to zero.
// - control bit 13 stops change notice while idle.
// - direction 6140, readback 6150, latch 6160, open-drain 6170.
module pfg_port
    import pfg_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    input  wire logic              ref_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              idle_i,
    input  wire logic [PIN_W-1:0]  pin_in_i,
    output logic      [PIN_W-1:0]  pin_out_o,
    output logic      [PIN_W-1:0]  pin_oe_o,
    output logic                   pin_change_detect_o
);
    localparam logic [PIN_W-1:0] IMPL = LARGE_PKG ? MASK_LARGE : MASK_SMALL;

    function automatic pfg_sel_type decode(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] g;
        g = {a[ADDR_W-1:4], 4'h0};
        if (a[1:0] != 2'h0)          decode = PFG_SEL_NONE;
        else if (g == OFS_DIRECTION) decode = PFG_SEL_DIR;
        else if (g == OFS_READBACK)  decode = PFG_SEL_RB;
        else if (g == OFS_LATCH)     decode = PFG_SEL_LAT;
        else if (g == OFS_OPENDRAIN) decode = PFG_SEL_ODC;
        else if (g == OFS_CHANGECTL) decode = PFG_SEL_CTL;
        else                         decode = PFG_SEL_NONE;
    endfunction

    pfg_sel_type       sel;
    logic [1:0]        alias_sel;
    logic [PIN_W-1:0]  dir_q, dir_d, lat_q, lat_d, odc_q, odc_d, ctl_q, ctl_d;
    logic [PIN_W-1:0]  dir_n, lat_n, odc_n, ctl_n;
    logic [PIN_W-1:0]  level, change;
    logic [DATA_W-1:0] rdata_d;
    logic              det_d, det_q, active;
    pfg_pad_type       pad_d, pad_q;

    assign sel       = decode(addr_i);
    assign alias_sel = addr_i[3:2];

    pfg_pin_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .pins_i    (pin_in_i),
        .mask_i    (IMPL),
        .level_o   (level),
        .change_o  (change)
    );

    pfg_alias_upd u_dir (.cur_i(dir_q), .wdata_i(wdata_i[PIN_W-1:0]), .alias_i(alias_sel),
                         .mask_i(IMPL), .next_o(dir_n));
    pfg_alias_upd u_lat (.cur_i(lat_q), .wdata_i(wdata_i[PIN_W-1:0]), .alias_i(alias_sel),
                         .mask_i(IMPL), .next_o(lat_n));
    pfg_alias_upd u_odc (.cur_i(odc_q), .wdata_i(wdata_i[PIN_W-1:0]), .alias_i(alias_sel),
                         .mask_i(IMPL), .next_o(odc_n));
    pfg_alias_upd u_ctl (.cur_i(ctl_q), .wdata_i(wdata_i[PIN_W-1:0]), .alias_i(alias_sel),
                         .mask_i(CTL_MASK), .next_o(ctl_n));

    // a write to the readback address lands in the latch, as pins cannot be written
    always_comb begin
        dir_d = dir_q;
        lat_d = lat_q;
        odc_d = odc_q;
        ctl_d = ctl_q;
        if (wr_i) begin
            case (sel)
                PFG_SEL_DIR: dir_d = dir_n;
                PFG_SEL_RB:  lat_d = lat_n;
                PFG_SEL_LAT: lat_d = lat_n;
                PFG_SEL_ODC: odc_d = odc_n;
                PFG_SEL_CTL: ctl_d = ctl_n;
                default:     dir_d = dir_q;
            endcase
        end
    end

    // the latch has no defined reset in hardware; zero here so the pads never float x
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dir_q <= IMPL;
            lat_q <= LATCH_RST;
            odc_q <= OPENDRAIN_RST;
            ctl_q <= CTL_RST;
        end else begin
            dir_q <= dir_d;
            lat_q <= lat_d;
            odc_q <= odc_d;
            ctl_q <= ctl_d;
        end
    end

    // read path: one cycle later, upper halfword always zero
    always_comb begin
        rdata_d = '0;
        if (rd_i) begin
            case (sel)
                PFG_SEL_DIR: rdata_d = {16'h0000, dir_q};
                PFG_SEL_RB:  rdata_d = {16'h0000, level};
                PFG_SEL_LAT: rdata_d = {16'h0000, lat_q};
                PFG_SEL_ODC: rdata_d = {16'h0000, odc_q};
                PFG_SEL_CTL: rdata_d = {16'h0000, ctl_q};
                default:     rdata_d = '0;
            endcase
        end
    end

    // pad drive: open-drain outputs only pull low
    always_comb begin
        pad_d.out = lat_q & IMPL;
        pad_d.oe  = ~dir_q & IMPL & ~(odc_q & lat_q);
    end

    // change-notice flag: level, set by any implemented-pin edge while active, cleared on readback read
    assign active = ctl_q[CTL_ENABLE_BIT] && !(ctl_q[CTL_HALT_BIT] && idle_i);
    always_comb begin
        det_d = det_q;
        if (rd_i && sel == PFG_SEL_RB) begin
            det_d = 1'b0;
        end
        if (!ctl_q[CTL_ENABLE_BIT]) begin
            det_d = 1'b0;
        end else if (active && |change) begin
            det_d = 1'b1;                     // set wins over clear
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= '0;
            pad_q   <= '0;
            det_q   <= 1'b0;
        end else begin
            rdata_o <= rdata_d;
            pad_q   <= pad_d;
            det_q   <= det_d;
        end
    end

    assign pin_out_o           = pad_q.out;
    assign pin_oe_o            = pad_q.oe;
    assign pin_change_detect_o = det_q;

    // ---- assertions
    AST_DIR_RESET: assert property (@(posedge ref_clk_i)
        $rose(reset_n_i) |-> dir_q == IMPL) else $error("direction reset value wrong");
    AST_SET_ALIAS: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_i && sel == PFG_SEL_DIR && alias_sel == ALIAS_SET
        |=> dir_q == ($past(dir_q) | ($past(wdata_i[PIN_W-1:0]) & IMPL)))
        else $error("set alias failed");
    AST_CLR_ALIAS: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_i && sel == PFG_SEL_ODC && alias_sel == ALIAS_CLR
        |=> odc_q == ($past(odc_q) & ~$past(wdata_i[PIN_W-1:0])))
        else $error("clear alias failed");
    AST_INV_ALIAS: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_i && sel == PFG_SEL_LAT && alias_sel == ALIAS_INV
        |=> lat_q == ($past(lat_q) ^ ($past(wdata_i[PIN_W-1:0]) & IMPL)))
        else $error("invert alias failed");
    AST_UPPER_ZERO: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rdata_o[31:16] == 16'h0000 && (dir_q & ~IMPL) == '0 && (lat_q & ~IMPL) == '0)
        else $error("unimplemented bits not zero");
    AST_ODC_RESET: assert property (@(posedge ref_clk_i)
        $rose(reset_n_i) |-> odc_q == '0 && ctl_q == '0) else $error("reset value wrong");
    AST_DISABLED_QUIET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !ctl_q[CTL_ENABLE_BIT] |=> !pin_change_detect_o) else $error("detect while off");
    AST_IDLE_HALT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        ctl_q[CTL_HALT_BIT] && idle_i && !det_q |=> !det_q) else $error("detect in idle");
    AST_READ_DIR: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rd_i && addr_i == OFS_DIRECTION |=> rdata_o == {16'h0000, $past(dir_q)})
        else $error("direction read wrong");
    AST_INPUT_HIZ: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        ##1 ($past(dir_q) & pin_oe_o) == '0) else $error("input pin driven");

    // a plain write replaces the whole implemented field, nothing of the old value survives
    AST_BASE_WRITE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_i && sel == PFG_SEL_DIR && alias_sel == ALIAS_BASE
        |=> dir_q == ($past(wdata_i[PIN_W-1:0]) & IMPL))
        else $error("plain write failed");

    // read data stand one cycle only, so a stale word can never be taken twice
    AST_RDATA_IDLE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !rd_i |=> rdata_o == '0) else $error("read data without strobe");

    AST_UNMAPPED_READ: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rd_i && sel == PFG_SEL_NONE |=> rdata_o == '0) else $error("unmapped read not zero");

    AST_READ_RB: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rd_i && sel == PFG_SEL_RB |=> rdata_o == {16'h0000, $past(level)})
        else $error("readback read wrong");

    AST_READ_ODC: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rd_i && sel == PFG_SEL_ODC |=> rdata_o == {16'h0000, $past(odc_q)})
        else $error("open-drain read wrong");

    AST_PAD_OUT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        ##1 pin_out_o == ($past(lat_q) & IMPL)) else $error("pad level wrong");

    // an open-drain bit with latch high must never drive the pad high
    AST_ODC_HIGH_OFF: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        ##1 ($past(odc_q) & $past(lat_q) & pin_oe_o) == '0)
        else $error("open-drain pad driven high");

    AST_CTL_UPPER: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (ctl_q & ~CTL_MASK) == '0) else $error("control reserved bits set");

    AST_DETECT_SET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        active && |change |=> det_q) else $error("edge not flagged");
endmodule // pfg_port
`default_nettype wire

// File: pfg_board_model.sv
// pfg_board_model: board circuitry on the port pins, an external source behind each pad.
// assumes the pad outputs are registered in the port's own clock domain.
`timescale 1ns/1ps
`default_nettype none
module pfg_board_model
    import pfg_pkg::*;
(
    input  wire logic [PIN_W-1:0] pin_out_i,
    input  wire logic [PIN_W-1:0] pin_oe_i,
    input  wire logic [PIN_W-1:0] ext_i,
    output logic      [PIN_W-1:0] pin_o
);
    // a released pad follows the board source, a driven pad shows its own level
    assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule // pfg_board_model
`default_nettype wire

// File: tb_top.sv
// tb_top: register-level tests of the port, pads looped back through the board model.
// assumes the large pin-count variant and single-cycle strobes with read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pfg_pkg::*;
    logic              clk;
    logic              rst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              idle;
    logic [PIN_W-1:0]  pins;
    logic [PIN_W-1:0]  pout;
    logic [PIN_W-1:0]  poe;
    logic [PIN_W-1:0]  ext;
    logic              det;
    logic [DATA_W-1:0] v;
    int                error_cnt;
    int                n_tests;

    pfg_port #(.LARGE_PKG(1'b1)) uut (.ref_clk_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .idle_i(idle), .pin_in_i(pins), .pin_out_o(pout),
        .pin_oe_o(poe), .pin_change_detect_o(det));
    pfg_board_model board (.pin_out_i(pout), .pin_oe_i(poe), .ext_i(ext), .pin_o(pins));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr32(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so they are taken there
    task automatic chk_rd(input string nm, input logic [15:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        v = rdata;
        chk(nm, e, v);
    endtask

    task automatic wait_det;
        int i;
        for (i = 0; i < 10 && det !== 1'b1; i++) begin
            cyc(1);
        end
        chk("detect_set", 32'h1, {31'h0, det});
        if (det !== 1'b1) begin
            wrap_up();
        end
    endtask

    initial begin
        clk = 1'b0; rst_n = 1'b0; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0; idle = 1'b0; ext = '0;
        error_cnt = 0;
        n_tests = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        chk_rd("dir_reset", OFS_DIRECTION, {16'h0000, MASK_LARGE});
        chk_rd("odc_reset", OFS_OPENDRAIN, 32'h00000000);
        chk_rd("ctl_reset", OFS_CHANGECTL, 32'h00000000);
        chk("oe_reset", 32'h0, {16'h0000, poe});
        $display("test reset done");
        wr32(OFS_DIRECTION, 32'hffffffff);
        chk_rd("dir_mask", 16'h6140, 32'h0000313f);
        wr32(16'h6144, 32'h00000001);
        chk_rd("dir_clr", 16'h6140, 32'h0000313e);
        wr32(16'h6148, 32'h00000001);
        chk_rd("dir_set", 16'h6140, 32'h0000313f);
        wr32(16'h614c, 32'h00000141);
        chk_rd("dir_inv", 16'h6140, 32'h0000303e);
        $display("test aliases done");
        wr32(OFS_DIRECTION, 32'h00000000);
        wr32(OFS_LATCH, 32'hffff1234);
        cyc(2);
        chk("pad_out", 32'h1034, {16'h0000, pout});
        chk("pad_oe", 32'h313f, {16'h0000, poe});
        cyc(2);
        chk_rd("readback", 16'h6150, 32'h00001034);
        chk_rd("latch", 16'h6160, 32'h00001034);
        // open-drain bits with latch 1 release their pads
        wr32(16'h6178, 32'h00000014);
        cyc(2);
        chk("odc_oe", 32'h312b, {16'h0000, poe});
        chk_rd("odc", 16'h6170, 32'h00000014);
        wr32(16'h6174, 32'h00000004);
        chk_rd("odc_clr", 16'h6170, 32'h00000010);
        wr32(16'h616c, 32'h0000ffff);
        chk_rd("lat_inv", 16'h6160, 32'h0000210b);
        $display("test pads done");
        wr32(16'h6148, 32'h0000ffff);
        wr32(OFS_CHANGECTL, 32'hffffffff);
        chk_rd("ctl", OFS_CHANGECTL, 32'h0000a000);
        cyc(4);
        chk_rd("readback_in", 16'h6150, 32'h00000000);
        chk("detect_clr", 32'h0, {31'h0, det});
        @(posedge clk);
        idle <= 1'b1;
        ext  <= 16'h0001;
        cyc(8);
        chk("detect_idle", 32'h0, {31'h0, det});
        @(posedge clk);
        idle <= 1'b0;
        ext  <= 16'h0000;
        wait_det();
        chk_rd("readback_clr", 16'h6150, 32'h00000000);
        chk("detect_read", 32'h0, {31'h0, det});
        wr32(16'h6184, 32'h00008000);
        chk_rd("ctl_clr", OFS_CHANGECTL, 32'h00002000);
        @(posedge clk);
        ext <= 16'h0001;
        cyc(8);
        chk("detect_off", 32'h0, {31'h0, det});
        chk_rd("unmapped", 16'h6190, 32'h00000000);
        $display("test change notice done");
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
